// *** core/pled_core.sv ***
// PHY LED controller: polarity sense, duplex strap, LED functions
//
// Contract
// - Sense LED wiring at reset, then drive default
// - Polarity latched only at reset
// - Second LED sourcing clears duplex bit
// - Second LED sinking sets duplex bit
// - Codes 1000-1011 give on, off, blinks
// - Codes 0001,0010,0011,0111 show stretchable activity
// - Codes 0100, 0101 follow link, duplex
// - Combined codes 1100-1110 always stretched
// - Second LED field in bits 7-4
// - Stretch length select in bits 3-2
// - Stretch lengths 40, 70, 140 ms
// - Stretch enable bit 1 lengthens events
// - Register reached only via management port
`default_nettype none
module pled_core #(
    parameter longint NORMAL_CYC = pled_pkg::NORMAL_CYC,
    parameter longint MEDIUM_CYC = pled_pkg::MEDIUM_CYC,
    parameter longint LONG_CYC = pled_pkg::LONG_CYC,
    parameter longint FAST_CYC = pled_pkg::FAST_CYC,
    parameter longint SLOW_CYC = pled_pkg::SLOW_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    // Management port access to the LED control register
    input wire logic mgmt_wr,
    input wire logic [15:0] mgmt_wdata,
    output logic [15:0] phy_led_control,
    // PHY status and activity from the same clock domain
    input wire logic link_up,
    input wire logic full_duplex,
    input wire logic tx_active,
    input wire logic rx_active,
    input wire logic col_active,
    // Duplex mode preset for the PHY control register
    output logic phy_duplex_mode_bit,
    // LED pins: input, output, enable (low while driving)
    input wire logic led_a_pin_i,
    output logic led_a_pin_o,
    output logic led_a_pin_oe_n,
    input wire logic led_b_pin_i,
    output logic led_b_pin_o,
    output logic led_b_pin_oe_n
);
    localparam int W = pled_pkg::CNT_W;

    // Reset sense sequencer states
    typedef enum logic [1:0] {
        PLED_SENSE = 2'b01,
        PLED_RUN = 2'b10
    } pled_state_t;

    pled_state_t state_reg;
    logic [4:0] sense_cnt_reg; // Cycles left before sampling
    logic [1:0] a_sync_reg; // Synchroniser for first LED pin
    logic [1:0] b_sync_reg; // Synchroniser for second LED pin
    logic a_sinks_reg; // First LED lit by sinking current
    logic b_sinks_reg; // Second LED lit by sinking current
    logic [15:0] ctrl_reg; // LED control register
    logic dpx_reg; // Duplex mode preset
    logic [W-1:0] blink_f_reg; // Fast blink phase counter
    logic [W-1:0] blink_s_reg; // Slow blink phase counter
    logic fast_reg; // Fast blink phase
    logic slow_reg; // Slow blink phase
    logic a_on_reg; // First LED lit state
    logic b_on_reg; // Second LED lit state
    logic a_drv_reg; // First pin output level
    logic b_drv_reg; // Second pin output level
    logic oe_n_reg; // Pins released while sensing
    logic [W-1:0] str_len; // Chosen stretch length
    logic str_en; // Stretch enable
    logic txrx_active; // Transmit or receive activity
    logic sense_done; // Last cycle of the sense window
    logic [3:0] act_ev; // Activity sources: tx, rx, col, tx-or-rx
    logic [3:0] act_st; // Always stretched view of each source
    logic [3:0] act_sh; // View that honours the stretch enable
    logic tx_st, rx_st, col_st, txrx_st; // Always stretched
    logic tx_sh, rx_sh, col_sh, txrx_sh; // Stretchable view

    // Pin synchronisers; the first stage feeds only the second
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            a_sync_reg <= 2'h0;
            b_sync_reg <= 2'h0;
        end else begin
            a_sync_reg <= {a_sync_reg[0], led_a_pin_i};
            b_sync_reg <= {b_sync_reg[0], led_b_pin_i};
        end
    end

    // Sense window after reset, then run forever until next reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= PLED_SENSE;
            sense_cnt_reg <= 5'(pled_pkg::SENSE_CYC);
        end else begin
            unique case (state_reg)
                PLED_SENSE: begin
                    if (sense_cnt_reg == 5'h0) begin
                        state_reg <= PLED_RUN;
                    end else begin
                        sense_cnt_reg <= sense_cnt_reg - 5'h1;
                    end
                end
                PLED_RUN: begin
                    // Stays here until the next reset
                    state_reg <= PLED_RUN;
                end
                default: begin
                    state_reg <= PLED_SENSE;
                end
            endcase
        end
    end

    // Sampling point: the pins have been released long enough for the
    // LED to pull them to its far terminal, and the synchroniser is full
    assign sense_done = (state_reg == PLED_SENSE) && (sense_cnt_reg == 5'h0);

    // Polarity capture: an undriven pin pulled high means LED to supply,
    // so the pin sinks; pulled low means it sources. Captured once per
    // reset, so rewiring while running waits for the next reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            a_sinks_reg <= 1'b0;
            b_sinks_reg <= 1'b0;
        end else if (sense_done) begin
            a_sinks_reg <= a_sync_reg[1];
            b_sinks_reg <= b_sync_reg[1];
        end
    end

    // Duplex preset from the second pin's wiring: sinking gives full
    // duplex, sourcing gives half duplex
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dpx_reg <= 1'b0;
        end else if (sense_done) begin
            dpx_reg <= b_sync_reg[1];
        end
    end

    // LED control register, written through the management port only
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= pled_pkg::LED_CTRL_RST;
        end else if (mgmt_wr) begin
            // Stored as written; reserved bits are software's duty
            ctrl_reg <= mgmt_wdata;
        end
    end

    // Stretch length selection; reserved code falls back to normal
    always_comb begin
        unique case (ctrl_reg[pled_pkg::STR_LEN_HI:pled_pkg::STR_LEN_LO])
            pled_pkg::STR_MEDIUM: str_len = W'(MEDIUM_CYC);
            pled_pkg::STR_LONG: str_len = W'(LONG_CYC);
            default: str_len = W'(NORMAL_CYC);
        endcase
    end

    assign str_en = ctrl_reg[pled_pkg::STR_EN_BIT];
    assign txrx_active = tx_active || rx_active;

    // Fast blink phase: flips every FAST_CYC clocks
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            blink_f_reg <= '0;
            fast_reg <= 1'b0;
        end else if (blink_f_reg == W'(FAST_CYC - 1)) begin
            // Half period over: wrap and flip the phase
            blink_f_reg <= '0;
            fast_reg <= ~fast_reg;
        end else begin
            // Still inside the half period
            blink_f_reg <= blink_f_reg + 1'b1;
        end
    end

    // Slow blink phase: flips every SLOW_CYC clocks
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            blink_s_reg <= '0;
            slow_reg <= 1'b0;
        end else if (blink_s_reg == W'(SLOW_CYC - 1)) begin
            // Half period over: wrap and flip the phase
            blink_s_reg <= '0;
            slow_reg <= ~slow_reg;
        end else begin
            // Still inside the half period
            blink_s_reg <= blink_s_reg + 1'b1;
        end
    end

    // Activity sources in stretcher order
    assign act_ev = {txrx_active, col_active, rx_active, tx_active};

    // One stretcher per activity source; each always stretches and the
    // enable bit only chooses which view the stretchable codes see
    generate
        for (genvar i = 0; i < 4; i++) begin : g_str
            pled_stretch #(
                .CNT_W(W)
            ) u_str (
                .mclk(mclk),
                .rst(rst),
                .event_in(act_ev[i]),
                .stretch_on(1'b1),
                .length(str_len),
                .active(act_st[i])
            );
            // Stretchable view honours the enable bit
            assign act_sh[i] = str_en ? act_st[i] : act_ev[i];
        end
    endgenerate

    // Named views for the function decoder
    assign {txrx_st, col_st, rx_st, tx_st} = act_st;
    assign {txrx_sh, col_sh, rx_sh, tx_sh} = act_sh;

    // Decode one LED function field into a lit state
    function automatic logic led_fn(input logic [3:0] code,
            input logic tx, input logic rx, input logic col,
            input logic txrx, input logic rxs, input logic txrxs,
            input logic cols, input logic lnk, input logic dpx,
            input logic fst, input logic slw);
        logic lit;
        lit = 1'b0;
        unique case (code)
            pled_pkg::FN_TX: lit = tx;
            pled_pkg::FN_RX: lit = rx;
            pled_pkg::FN_COL: lit = col;
            pled_pkg::FN_TXRX: lit = txrx;
            pled_pkg::FN_LINK: lit = lnk;
            pled_pkg::FN_DPX: lit = dpx;
            pled_pkg::FN_ON: lit = 1'b1;
            pled_pkg::FN_OFF: lit = 1'b0;
            pled_pkg::FN_BLK_FAST: lit = fst;
            pled_pkg::FN_BLK_SLOW: lit = slw;
            pled_pkg::FN_LINK_RX: lit = lnk ^ rxs;
            pled_pkg::FN_LINK_TXRX: lit = lnk ^ txrxs;
            pled_pkg::FN_DPX_COL: lit = dpx ^ cols;
            default: lit = 1'b0; // Reserved codes stay dark
        endcase
        return lit;
    endfunction : led_fn

    // Lit state of each LED from its own field
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            a_on_reg <= 1'b0;
            b_on_reg <= 1'b0;
        end else begin
            a_on_reg <= led_fn(ctrl_reg[pled_pkg::FN_A_HI:pled_pkg::FN_A_LO],
                tx_sh, rx_sh, col_sh, txrx_sh, rx_st, txrx_st, col_st,
                link_up, full_duplex, fast_reg, slow_reg);
            b_on_reg <= led_fn(ctrl_reg[pled_pkg::FN_B_HI:pled_pkg::FN_B_LO],
                tx_sh, rx_sh, col_sh, txrx_sh, rx_st, txrx_st, col_st,
                link_up, full_duplex, fast_reg, slow_reg);
        end
    end

    // Pin release: undriven through reset and the sense window so the
    // LED alone sets the pin level
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            oe_n_reg <= 1'b1;
        end else begin
            oe_n_reg <= (state_reg != PLED_RUN);
        end
    end

    // Pin level: lit state flipped for a sinking LED, which lights when
    // the pin is pulled low
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            a_drv_reg <= 1'b0;
            b_drv_reg <= 1'b0;
        end else begin
            a_drv_reg <= a_on_reg ^ a_sinks_reg;
            b_drv_reg <= b_on_reg ^ b_sinks_reg;
        end
    end

    // Register read-back
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            phy_led_control <= pled_pkg::LED_CTRL_RST;
        end else begin
            phy_led_control <= ctrl_reg;
        end
    end

    // Outputs straight from their flops
    assign phy_duplex_mode_bit = dpx_reg;
    assign led_a_pin_o = a_drv_reg;
    assign led_b_pin_o = b_drv_reg;
    assign led_a_pin_oe_n = oe_n_reg;
    assign led_b_pin_oe_n = oe_n_reg;
endmodule : pled_core
`default_nettype wire

// *** core/pled_pkg.sv ***
// Constants shared by the PHY LED controller
`default_nettype none
package pled_pkg;
    // LED control register field positions
    localparam int FN_A_HI = 11;
    localparam int FN_A_LO = 8;
    localparam int FN_B_HI = 7;
    localparam int FN_B_LO = 4;
    localparam int STR_LEN_HI = 3;
    localparam int STR_LEN_LO = 2;
    localparam int STR_EN_BIT = 1;
    // Reset value of the LED control register
    localparam logic [15:0] LED_CTRL_RST = 16'h3422;
    // LED function codes
    localparam logic [3:0] FN_TX = 4'h1;
    localparam logic [3:0] FN_RX = 4'h2;
    localparam logic [3:0] FN_COL = 4'h3;
    localparam logic [3:0] FN_LINK = 4'h4;
    localparam logic [3:0] FN_DPX = 4'h5;
    localparam logic [3:0] FN_TXRX = 4'h7;
    localparam logic [3:0] FN_ON = 4'h8;
    localparam logic [3:0] FN_OFF = 4'h9;
    localparam logic [3:0] FN_BLK_FAST = 4'ha;
    localparam logic [3:0] FN_BLK_SLOW = 4'hb;
    localparam logic [3:0] FN_LINK_RX = 4'hc;
    localparam logic [3:0] FN_LINK_TXRX = 4'hd;
    localparam logic [3:0] FN_DPX_COL = 4'he;
    // Stretch length select codes
    localparam logic [1:0] STR_NORMAL = 2'h0;
    localparam logic [1:0] STR_MEDIUM = 2'h1;
    localparam logic [1:0] STR_LONG = 2'h2;
    // Clock and times
    localparam longint CLK_HZ = 40000000;
    localparam longint NORMAL_STRETCH_MS = 40;
    localparam longint MEDIUM_STRETCH_MS = 70;
    localparam longint LONG_STRETCH_MS = 140;
    localparam longint FAST_BLINK_MS = 100;
    localparam longint SLOW_BLINK_MS = 500;
    localparam longint NORMAL_CYC = CLK_HZ * NORMAL_STRETCH_MS / 1000;
    localparam longint MEDIUM_CYC = CLK_HZ * MEDIUM_STRETCH_MS / 1000;
    localparam longint LONG_CYC = CLK_HZ * LONG_STRETCH_MS / 1000;
    localparam longint FAST_CYC = CLK_HZ * FAST_BLINK_MS / 1000;
    localparam longint SLOW_CYC = CLK_HZ * SLOW_BLINK_MS / 1000;
    // Cycles the pins are left undriven at reset before polarity is sampled
    localparam int SENSE_CYC = 16;
    // Width of timing counters; must hold the slow blink half period
    localparam int CNT_W = 25;
endpackage : pled_pkg
`default_nettype wire

// *** core/pled_stretch.sv ***
// Pulse stretcher for one LED activity indication
`default_nettype none
module pled_stretch #(
    parameter int CNT_W = 25
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic event_in,
    input wire logic stretch_on,
    input wire logic [CNT_W-1:0] length,
    output logic active
);
    logic [CNT_W-1:0] count_reg; // Remaining stretch cycles

    // Reload on every event, count down afterwards
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else if (event_in) begin
            count_reg <= length;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    // Shown while the event lasts, plus stretch time when enabled
    assign active = event_in || (stretch_on && count_reg != '0);
endmodule : pled_stretch
`default_nettype wire

// *** tb/pled_chk.sv ***
// Port checker for the LED controller
`default_nettype none
module pled_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic mgmt_wr,
    input wire logic [15:0] mgmt_wdata,
    input wire logic [15:0] phy_led_control,
    input wire logic link_up,
    input wire logic full_duplex,
    input wire logic tx_active,
    input wire logic phy_duplex_mode_bit,
    input wire logic led_a_pin_i,
    input wire logic led_a_pin_o,
    input wire logic led_a_pin_oe_n,
    input wire logic led_b_pin_i,
    input wire logic led_b_pin_o,
    input wire logic led_b_pin_oe_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic [4:0] cyc_reg; // Cycles since reset, saturating
    logic pull_a_reg; // Pin level last seen while released
    logic pull_b_reg;
    logic settled; // Sensing long over
    assign settled = cyc_reg == 5'h1f;
    // Count up after reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) cyc_reg <= 5'h0;
        else if (!settled) cyc_reg <= cyc_reg + 5'h1;
    end
    // Remember the pull level, frozen once the pin is driven
    always_ff @(posedge mclk) begin
        if (led_a_pin_oe_n) pull_a_reg <= led_a_pin_i;
        if (led_b_pin_oe_n) pull_b_reg <= led_b_pin_i;
    end
    sequence s_a(logic [3:0] c, logic en);
        (settled && phy_led_control[11:8] == c && en) [*4];
    endsequence
    sequence s_b(logic [3:0] c, logic en);
        (settled && phy_led_control[7:4] == c && en) [*4];
    endsequence
    a_ctrl_write: assert property (
        mgmt_wr |-> ##2 phy_led_control == $past(mgmt_wdata, 2))
        else $error("control word not taken");
    a_sense_wait: assert property (
        cyc_reg < 5'hc |-> led_a_pin_oe_n && led_b_pin_oe_n)
        else $error("pin driven during sensing");
    a_drive_after: assert property (
        settled |-> !led_a_pin_oe_n && !led_b_pin_oe_n)
        else $error("pin not driven after sensing");
    a_duplex_strap: assert property (
        settled |-> phy_duplex_mode_bit == pull_b_reg)
        else $error("duplex preset wrong");
    a_fixed_on: assert property (
        s_a(pled_pkg::FN_ON, 1'b1) |-> led_a_pin_o ^ pull_a_reg)
        else $error("first led not on");
    a_fixed_off: assert property (
        s_b(pled_pkg::FN_OFF, 1'b1) |-> !(led_b_pin_o ^ pull_b_reg))
        else $error("second led not off");
    a_link_follow: assert property (
        s_a(pled_pkg::FN_LINK, link_up) |-> led_a_pin_o ^ pull_a_reg)
        else $error("led not showing link");
    a_dpx_follow: assert property (
        s_b(pled_pkg::FN_DPX, !full_duplex)
        |-> !(led_b_pin_o ^ pull_b_reg))
        else $error("led not showing half duplex");
    a_raw_tx: assert property (
        s_a(pled_pkg::FN_TX, tx_active && !phy_led_control[1])
        |-> led_a_pin_o ^ pull_a_reg)
        else $error("led not showing transmit");
endmodule : pled_chk
bind pled_core pled_chk chk (.mclk, .rst, .mgmt_wr, .mgmt_wdata,
    .phy_led_control, .link_up, .full_duplex, .tx_active,
    .phy_duplex_mode_bit, .led_a_pin_i, .led_a_pin_o, .led_a_pin_oe_n,
    .led_b_pin_i, .led_b_pin_o, .led_b_pin_oe_n);
`default_nettype wire

// *** tb/pled_leds.sv ***
// Model of the two LEDs hanging on the LED pins
`default_nettype none
module pled_leds (
    input wire logic sink_a,
    input wire logic sink_b,
    input wire logic a_o,
    input wire logic a_oe_n,
    input wire logic b_o,
    input wire logic b_oe_n,
    output logic a_i,
    output logic b_i,
    output logic lit_a,
    output logic lit_b
);
    // A released pin is pulled to the LED's far terminal level
    assign a_i = a_oe_n ? sink_a : a_o;
    assign b_i = b_oe_n ? sink_b : b_o;
    // A sinking LED lights on a low drive, a sourcing one on a high
    assign lit_a = !a_oe_n && (a_o ^ sink_a);
    assign lit_b = !b_oe_n && (b_o ^ sink_b);
endmodule : pled_leds
`default_nettype wire

// *** tb/tb_phy_led_controller.sv ***
// Self-checking bench for the LED controller
`default_nettype none
module tb_phy_led_controller;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst, mgmt_wr, link_up, full_duplex, tx_active, rx_active;
    logic col_active, sink_a, sink_b, a_i, a_o, a_oe_n, b_i, b_o, b_oe_n;
    logic lit_a, lit_b, dpx;
    logic [15:0] wdata, ctrl, obs;
    logic [31:0] rnd = 32'h417d0985; // Generator state
    logic [15:0] exp_q[$]; // Expected results in order
    int n_errors = 0, cmp_count = 0, cycles = 0;
    event ev; // A result is ready in obs
    localparam logic [3:0] CODES [13] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
        4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he};
    localparam int SLEN [5] = '{10, 20, 40, 10, 1}; // Lit cycles per pulse
    pled_core #(.NORMAL_CYC(10), .MEDIUM_CYC(20), .LONG_CYC(40),
        .FAST_CYC(4), .SLOW_CYC(8)) dut (.mclk(mclk), .rst(rst),
        .mgmt_wr(mgmt_wr), .mgmt_wdata(wdata), .phy_led_control(ctrl),
        .link_up(link_up), .full_duplex(full_duplex),
        .tx_active(tx_active), .rx_active(rx_active),
        .col_active(col_active), .phy_duplex_mode_bit(dpx),
        .led_a_pin_i(a_i), .led_a_pin_o(a_o), .led_a_pin_oe_n(a_oe_n),
        .led_b_pin_i(b_i), .led_b_pin_o(b_o), .led_b_pin_oe_n(b_oe_n));
    pled_leds leds (.sink_a(sink_a), .sink_b(sink_b), .a_o(a_o),
        .a_oe_n(a_oe_n), .b_o(b_o), .b_oe_n(b_oe_n), .a_i(a_i), .b_i(b_i),
        .lit_a(lit_a), .lit_b(lit_b));
    // Clock at 40 MHz
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Next xorshift value
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    // Expected light for a code with steady inputs
    function automatic logic exp_lit(input logic [3:0] c);
        case (c)
            4'h1: return tx_active;
            4'h2: return rx_active;
            4'h3: return col_active;
            4'h4: return link_up;
            4'h5: return full_duplex;
            4'h7: return tx_active | rx_active;
            4'h8: return 1'b1;
            4'hc: return link_up ^ rx_active;
            4'hd: return link_up ^ (tx_active | rx_active);
            4'he: return full_duplex ^ col_active;
            default: return 1'b0;
        endcase
    endfunction : exp_lit
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        cmp_count++;
        if (seen !== want) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time,
                seen, want);
        end
    endtask : check
    // Monitor compares each result with the oldest note
    always @(ev) check(obs, exp_q.pop_front());
    task automatic expect_val(input logic [15:0] seen,
            input logic [15:0] want);
        exp_q.push_back(want);
        obs = seen;
        -> ev;
        #1;
    endtask : expect_val
    task automatic write_ctrl(input logic [15:0] d);
        @(posedge mclk);
        mgmt_wr <= 1'b1;
        wdata <= d;
        @(posedge mclk);
        mgmt_wr <= 1'b0;
    endtask : write_ctrl
    // Count lit cycles and level changes of the first LED
    task automatic measure(input int n, output int ones, output int tg);
        logic last;
        ones = 0;
        tg = 0;
        last = lit_a;
        repeat (n) begin
            @(negedge mclk);
            ones += int'(lit_a);
            tg += int'(lit_a != last);
            last = lit_a;
        end
    endtask : measure
    task automatic do_reset(input logic sa, input logic sb);
        @(posedge mclk);
        rst <= 1'b1;
        sink_a <= sa;
        sink_b <= sb;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        repeat (40) @(negedge mclk);
        expect_val(ctrl, pled_pkg::LED_CTRL_RST);
        expect_val(16'(dpx), 16'(sb));
    endtask : do_reset
    // Every valid code on both LEDs, random stretch setup and status
    task automatic run_codes();
        logic [3:0] c;
        logic [15:0] w;
        for (int k = 0; k < 26; k++) begin
            rnd = xs(rnd);
            c = CODES[k % 13];
            // Pass-wise fixed cases: raw transmit, link lit, half duplex
            w = {4'h3, c, c, rnd[3:2], rnd[1] && k != 13, 1'b0};
            write_ctrl(w);
            {link_up, full_duplex, tx_active, rx_active, col_active} <=
                (rnd[8:4] | {k == 3, 1'b0, k == 13, 2'h0}) &
                ~{1'b0, k == 17, 3'h0};
            repeat (60) @(negedge mclk);
            expect_val(ctrl, w);
            if (c < 4'ha || c > 4'hb) begin
                expect_val(16'(lit_a), 16'(exp_lit(c)));
                expect_val(16'(lit_b), 16'(exp_lit(c)));
            end
        end
    endtask : run_codes
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        int ones, tg;
        rst = 1'b1;
        mgmt_wr = 1'b0;
        wdata = 16'h0;
        {link_up, full_duplex, tx_active, rx_active, col_active} = 5'h0;
        sink_a = 1'b1;
        sink_b = 1'b0;
        do_reset(1'b1, 1'b0);
        run_codes();
        @(posedge mclk);
        {link_up, full_duplex, tx_active, rx_active, col_active} <= 5'h0;
        // One receive pulse per stretch setting
        for (int s = 0; s < 5; s++) begin
            write_ctrl({8'h32, 4'h9, s[1:0], s < 4, 1'b0});
            repeat (60) @(posedge mclk);
            rx_active <= 1'b1;
            @(posedge mclk);
            rx_active <= 1'b0;
            measure(80, ones, tg);
            expect_val(16'(ones >= SLEN[s] && ones <= SLEN[s] + 4),
                16'h1);
        end
        // Fast then slow blink, half periods of 4 and 8 cycles
        for (int s = 0; s < 2; s++) begin
            write_ctrl(16'h3a90 + 16'(s << 8));
            repeat (8) @(posedge mclk);
            measure(48, ones, tg);
            expect_val(16'(tg >= (s ? 5 : 11) && tg <= (s ? 7 : 13)),
                16'h1);
        end
        // Rewire the second LED while running
        @(posedge mclk);
        sink_b <= 1'b1;
        repeat (40) @(negedge mclk);
        expect_val(16'(dpx), 16'h0);
        do_reset(1'b0, 1'b1);
        run_codes();
        stop_test();
    end
endmodule : tb_phy_led_controller
`default_nettype wire
